// ==== rtl/lcis_pkg.sv ====
// Package with register map, field layout, mux codes and source bundle of the cell input stage.
package lcis_pkg;

    // Register byte offsets on the Avalon-MM slave.
    localparam logic [3:0] LCIS_SEL_OFF = 4'h0;
    localparam logic [3:0] LCIS_GLSL_OFF = 4'h4;
    localparam logic [3:0] LCIS_POL_OFF = 4'h8;
    localparam logic [3:0] LCIS_STAT_OFF = 4'hC;

    // Values after reset.
    localparam logic [15:0] LCIS_SEL_RESET = 16'h0000;
    localparam logic [15:0] LCIS_GLSL_RESET = 16'h0000;
    localparam logic [1:0] LCIS_POL_RESET = 2'h0;

    // Implemented bits of the source select register.
    localparam logic [15:0] LCIS_SEL_MASK = 16'h0077;

    // Field positions.
    localparam int LCIS_SRC2_LSB = 4;
    localparam int LCIS_SRC1_LSB = 0;
    localparam int LCIS_G2_LSB = 8;
    localparam int LCIS_G1_LSB = 0;

    // Source 2 select codes.
    localparam logic [2:0] LCIS_SRC2_MULTI2 = 3'h7;
    localparam logic [2:0] LCIS_SRC2_MULTI1 = 3'h6;
    localparam logic [2:0] LCIS_SRC2_HIGH = 3'h5;
    localparam logic [2:0] LCIS_SRC2_ADC_EOC = 3'h4;
    localparam logic [2:0] LCIS_SRC2_SER_TX = 3'h3;
    localparam logic [2:0] LCIS_SRC2_CMP1 = 3'h2;
    localparam logic [2:0] LCIS_SRC2_OTHER = 3'h1;
    localparam logic [2:0] LCIS_SRC2_PIN_B = 3'h0;

    // Source 1 select codes.
    localparam logic [2:0] LCIS_SRC1_SINGLE5 = 3'h7;
    localparam logic [2:0] LCIS_SRC1_SINGLE4 = 3'h6;
    localparam logic [2:0] LCIS_SRC1_HIGH = 3'h5;
    localparam logic [2:0] LCIS_SRC1_FAST_OSC = 3'h4;
    localparam logic [2:0] LCIS_SRC1_LP_OSC = 3'h3;
    localparam logic [2:0] LCIS_SRC1_SEC_OSC = 3'h2;
    localparam logic [2:0] LCIS_SRC1_TCY = 3'h1;
    localparam logic [2:0] LCIS_SRC1_PIN_A = 3'h0;

    // Raw signals offered to the selection multiplexers, plus sources 3 and 4 that feed the gates directly.
    typedef struct packed {
        logic multi_compare_unit_2_evt;
        logic multi_compare_unit_1_evt;
        logic adc_eoc;
        logic serial1_tx;
        logic serial2_tx;
        logic comparator1_out;
        logic other_cell_out;
        logic cell_input_pin_b;
        logic single_compare_unit_5_evt;
        logic single_compare_unit_4_evt;
        logic fast_internal_osc;
        logic low_power_internal_osc;
        logic secondary_osc;
        logic sys_clk_tcy;
        logic cell_input_pin_a;
        logic source3;
        logic source4;
    } lcis_sources_t;

endpackage

// ==== rtl/lcis_top.sv ====
// Input selection and gates 1 and 2 of a configurable logic cell with an Avalon-MM slave.
`timescale 1ns/1ns

// Summary of operation
// - Source 2 bits 6-4: 111/110 compare events, 101 high, 100 converter done.
// - Source 2 low codes: own serial transmit, comparator 1, other cell, pin B.
// - Select register bit 3 reads zero and ignores writes.
// - Source 1 bits 2-0: 111/110 single compare events, 101 high, 000 pin A.
// - Source 1 codes 100..001: fast, low-power, secondary oscillator, system clock.
// - Gate 2 enables in bits 15-8, true/negated pairs, source 4 down to 1.
// - Gate 1 enables in bits 7-0 in the same pairing order.
// - Each multiplexer offers its selected signal and its inverse to the gates.
// - Each gate ORs every enabled true and negated source signal.
// - A set gate invert bit inverts that gate's output, else passes it.
module lcis_top #(
    parameter int CELL_INDEX = 1
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire lcis_pkg::lcis_sources_t sources_i,
    output logic source1_o,
    output logic source2_o,
    output logic gate1_o,
    output logic gate2_o
);
    import lcis_pkg::*;

    // Only two cells exist; the serial port pick depends on which one this is.
    if (CELL_INDEX != 1 && CELL_INDEX != 2) begin : g_bad_cell
        $error("CELL_INDEX must be 1 or 2");
    end

    lcis_sources_t meta_reg;
    lcis_sources_t sync_reg;
    logic wait_reg;
    logic [31:0] rdata_reg;
    logic [15:0] sel_reg;
    logic [15:0] glsl_reg;
    logic [1:0] pol_reg;
    logic src1_reg;
    logic src2_reg;
    logic [1:0] gate_reg;
    logic src1_next;
    logic src2_next;
    logic [2:0] src1_code;
    logic [2:0] src2_code;
    logic [7:0] pair_vec;
    logic [1:0] gate_next;
    logic req;
    logic accept;
    logic [15:0] wd;
    logic [15:0] be_mask;

    // Every source comes from another domain, so it passes two flip-flops first.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= sources_i;
            sync_reg <= meta_reg;
        end
    end

    // A request is taken in the one cycle that waitrequest is low.
    assign req = avs_read_i | avs_write_i;
    assign accept = req & ~wait_reg;
    assign wd = avs_writedata_i[15:0];
    assign be_mask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

    // Waitrequest drops for one cycle after a request is seen, then rises again.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wait_reg <= 1'b1;
        end else begin
            wait_reg <= ~(req & wait_reg);
        end
    end

    // Read data is captured while waiting, so it stands when waitrequest is low.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (avs_read_i && wait_reg) begin
            unique case (avs_address_i)
                LCIS_SEL_OFF: rdata_reg <= {16'h0000, sel_reg & LCIS_SEL_MASK};
                LCIS_GLSL_OFF: rdata_reg <= {16'h0000, glsl_reg};
                LCIS_POL_OFF: rdata_reg <= {30'h0000_0000, pol_reg};
                LCIS_STAT_OFF: rdata_reg <= {28'h000_0000, gate_reg, src2_reg, src1_reg};
                default: rdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    // Source select register; unimplemented bits never store a one.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sel_reg <= LCIS_SEL_RESET;
        end else if (accept && avs_write_i && avs_address_i == LCIS_SEL_OFF) begin
            sel_reg <= ((wd & be_mask) | (sel_reg & ~be_mask)) & LCIS_SEL_MASK;
        end
    end

    // Gate enable register for gates 1 and 2, all clear after reset.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            glsl_reg <= LCIS_GLSL_RESET;
        end else if (accept && avs_write_i && avs_address_i == LCIS_GLSL_OFF) begin
            glsl_reg <= (wd & be_mask) | (glsl_reg & ~be_mask);
        end
    end

    // Gate invert bits: bit 0 for gate 1, bit 1 for gate 2.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pol_reg <= LCIS_POL_RESET;
        end else if (accept && avs_write_i && avs_address_i == LCIS_POL_OFF) begin
            if (avs_byteenable_i[0]) begin
                pol_reg <= wd[1:0];
            end
        end
    end

    assign src1_code = sel_reg[LCIS_SRC1_LSB +: 3];
    assign src2_code = sel_reg[LCIS_SRC2_LSB +: 3];

    // Source 2 multiplexer.
    always_comb begin
        unique case (src2_code)
            LCIS_SRC2_MULTI2: src2_next = sync_reg.multi_compare_unit_2_evt;
            LCIS_SRC2_MULTI1: src2_next = sync_reg.multi_compare_unit_1_evt;
            LCIS_SRC2_HIGH: src2_next = 1'b1;
            LCIS_SRC2_ADC_EOC: src2_next = sync_reg.adc_eoc;
            LCIS_SRC2_SER_TX: begin
                src2_next = (CELL_INDEX == 1) ? sync_reg.serial1_tx : sync_reg.serial2_tx;
            end
            LCIS_SRC2_CMP1: src2_next = sync_reg.comparator1_out;
            LCIS_SRC2_OTHER: src2_next = sync_reg.other_cell_out;
            LCIS_SRC2_PIN_B: src2_next = sync_reg.cell_input_pin_b;
        endcase
    end

    // Source 1 multiplexer.
    always_comb begin
        unique case (src1_code)
            LCIS_SRC1_SINGLE5: src1_next = sync_reg.single_compare_unit_5_evt;
            LCIS_SRC1_SINGLE4: src1_next = sync_reg.single_compare_unit_4_evt;
            LCIS_SRC1_HIGH: src1_next = 1'b1;
            LCIS_SRC1_FAST_OSC: src1_next = sync_reg.fast_internal_osc;
            LCIS_SRC1_LP_OSC: src1_next = sync_reg.low_power_internal_osc;
            LCIS_SRC1_SEC_OSC: src1_next = sync_reg.secondary_osc;
            LCIS_SRC1_TCY: src1_next = sync_reg.sys_clk_tcy;
            LCIS_SRC1_PIN_A: src1_next = sync_reg.cell_input_pin_a;
        endcase
    end

    // Selected sources are registered so the outputs come from flip-flops.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            src1_reg <= 1'b0;
            src2_reg <= 1'b0;
        end else begin
            src1_reg <= src1_next;
            src2_reg <= src2_next;
        end
    end

    // True and negated forms of sources 4 down to 1, in enable-bit order.
    assign pair_vec = {sync_reg.source4, ~sync_reg.source4,
                       sync_reg.source3, ~sync_reg.source3,
                       src2_reg, ~src2_reg, src1_reg, ~src1_reg};

    // Each gate ORs its enabled inputs, then applies its invert bit.
    for (genvar g = 0; g < 2; g++) begin : g_gate
        assign gate_next[g] = |(pair_vec & glsl_reg[g*8 +: 8]) ^ pol_reg[g];
    end

    // Gate outputs: index 0 uses bits 7-0, index 1 uses bits 15-8.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            gate_reg <= 2'h0;
        end else begin
            gate_reg <= gate_next;
        end
    end

    assign avs_readdata_o = rdata_reg;
    assign avs_waitrequest_o = wait_reg;
    assign source1_o = src1_reg;
    assign source2_o = src2_reg;
    assign gate1_o = gate_reg[0];
    assign gate2_o = gate_reg[1];

    // Checks on the selection and gate behaviour.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    property p_src2_high;
        (src2_code == LCIS_SRC2_HIGH) |=> src2_reg;
    endproperty
    a_src2_high: assert property (p_src2_high) else $error("source 2 not high");

    property p_src2_adc;
        (src2_code == LCIS_SRC2_ADC_EOC) |=> (src2_reg == $past(sync_reg.adc_eoc));
    endproperty
    a_src2_adc: assert property (p_src2_adc) else $error("source 2 not done flag");

    property p_src2_pin;
        (src2_code == LCIS_SRC2_PIN_B) |=> (src2_reg == $past(sync_reg.cell_input_pin_b));
    endproperty
    a_src2_pin: assert property (p_src2_pin) else $error("source 2 not pin B");

    // The serial line picked depends on which cell this instance is.
    property p_src2_ser;
        (src2_code == LCIS_SRC2_SER_TX) |=> (src2_reg ==
            $past((CELL_INDEX == 1) ? sync_reg.serial1_tx : sync_reg.serial2_tx));
    endproperty
    a_src2_ser: assert property (p_src2_ser) else $error("source 2 not serial line");

    property p_sel_bit3;
        (!wait_reg && avs_read_i && avs_address_i == LCIS_SEL_OFF) |-> !avs_readdata_o[3];
    endproperty
    a_sel_bit3: assert property (p_sel_bit3) else $error("select bit 3 not zero");

    property p_sel_store;
        (accept && avs_write_i && avs_address_i == LCIS_SEL_OFF && avs_byteenable_i[0])
            |=> (sel_reg[7:0] == ($past(avs_writedata_i[7:0]) & LCIS_SEL_MASK[7:0]));
    endproperty
    a_sel_store: assert property (p_sel_store) else $error("select codes not stored");

    property p_src1_high;
        (src1_code == LCIS_SRC1_HIGH) |=> src1_reg;
    endproperty
    a_src1_high: assert property (p_src1_high) else $error("source 1 not high");

    property p_src1_pin;
        (src1_code == LCIS_SRC1_PIN_A) |=> (src1_reg == $past(sync_reg.cell_input_pin_a));
    endproperty
    a_src1_pin: assert property (p_src1_pin) else $error("source 1 not pin A");

    property p_src1_tcy;
        (src1_code == LCIS_SRC1_TCY) |=> (src1_reg == $past(sync_reg.sys_clk_tcy));
    endproperty
    a_src1_tcy: assert property (p_src1_tcy) else $error("source 1 not sys clock");

    property p_src1_fast;
        (src1_code == LCIS_SRC1_FAST_OSC) |=> (src1_reg == $past(sync_reg.fast_internal_osc));
    endproperty
    a_src1_fast: assert property (p_src1_fast) else $error("source 1 not fast osc");

    property p_gate2_s1;
        (glsl_reg[9] && src1_reg && !pol_reg[1]) |=> gate2_o;
    endproperty
    a_gate2_s1: assert property (p_gate2_s1) else $error("gate 2 missed source 1");

    property p_gate2_s4n;
        (glsl_reg[14] && !sync_reg.source4 && !pol_reg[1]) |=> gate2_o;
    endproperty
    a_gate2_s4n: assert property (p_gate2_s4n) else $error("gate 2 missed neg src 4");

    property p_gate1_s1n;
        (glsl_reg[0] && !src1_reg && !pol_reg[0]) |=> gate1_o;
    endproperty
    a_gate1_s1n: assert property (p_gate1_s1n) else $error("gate 1 missed negated");

    property p_gate1_s4t;
        (glsl_reg[7] && sync_reg.source4 && !pol_reg[0]) |=> gate1_o;
    endproperty
    a_gate1_s4t: assert property (p_gate1_s4t) else $error("gate 1 missed source 4");

    property p_glsl_write;
        (accept && avs_write_i && avs_address_i == LCIS_GLSL_OFF && avs_byteenable_i[1:0] == 2'h3)
            |=> (glsl_reg == $past(avs_writedata_i[15:0]));
    endproperty
    a_glsl_write: assert property (p_glsl_write) else $error("enables not stored");

    property p_neg_only;
        (glsl_reg[7:0] == 8'h01 && !pol_reg[0]) |=> (gate1_o == !$past(src1_reg));
    endproperty
    a_neg_only: assert property (p_neg_only) else $error("negated form wrong");

    property p_or_any;
        (glsl_reg[7:0] == 8'h0A && !pol_reg[0]) |=> (gate1_o == $past(src1_reg | src2_reg));
    endproperty
    a_or_any: assert property (p_or_any) else $error("gate 1 not OR of sources");

    property p_invert;
        (glsl_reg[15:8] == 8'h00 && pol_reg[1]) |=> gate2_o;
    endproperty
    a_invert: assert property (p_invert) else $error("gate 2 not inverted");

    property p_none;
        (glsl_reg[7:0] == 8'h00 && !pol_reg[0]) |=> !gate1_o;
    endproperty
    a_none: assert property (p_none) else $error("empty gate 1 not zero");

    property p_wait_one;
        (req && wait_reg) |=> !wait_reg ##1 wait_reg;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("waitrequest not one cycle low");

    c_read_sel: cover property (accept && avs_read_i && avs_address_i == LCIS_SEL_OFF);
    c_gate1_hi: cover property ($rose(gate1_o));
    c_gate2_hi: cover property ($rose(gate2_o) && pol_reg[1] == 1'b0);
    c_pin_a: cover property (src1_code == LCIS_SRC1_PIN_A && src1_reg);
    c_ser_tx: cover property (src2_code == LCIS_SRC2_SER_TX && src2_reg);

endmodule

// ==== tb/lcis_src_model.sv ====
// Model of the peripherals, clocks and pins that feed the cell input stage.
`timescale 1ns/1ns
module lcis_src_model #(
    parameter int SEED = 58728
) (
    input wire logic clk_i,
    input wire logic step_i,
    output lcis_pkg::lcis_sources_t sources_o
);
    import lcis_pkg::*;
    int seed = SEED;
    // Every source takes a new random level on a step and holds it, clocks included.
    initial begin
        sources_o = '0;
        forever begin
            @(posedge clk_i);
            if (step_i) begin
                sources_o <= lcis_sources_t'($random(seed));
            end
        end
    end
endmodule

// ==== tb/tb_top.sv ====
// Testbench for the cell input stage: register access, source selection and gates.
`timescale 1ns/1ns
module tb_top;
    import lcis_pkg::*;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [3:0] adr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [3:0] be = 4'hF;
    logic [31:0] rdat;
    logic wait_o;
    logic step = 1'b0;
    lcis_sources_t src;
    logic s1, s2, g1, g2;
    logic [36:0] expq[$];
    logic [36:0] note;
    logic [15:0] glsl;
    logic [15:0] sel;
    logic [1:0] pol;
    logic [3:0] eo;
    int errors = 0;
    int checks = 0;
    int cycles = 0;
    int seed = 58728;

    lcis_top #(.CELL_INDEX(1)) dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
        .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o),
        .sources_i(src), .source1_o(s1), .source2_o(s2), .gate1_o(g1), .gate2_o(g2));

    lcis_src_model #(.SEED(58728)) model (.clk_i(clk_i), .step_i(step), .sources_o(src));

    // The clock toggles every 5 ns for a 100 MHz rate.
    initial begin
        forever #5 clk_i = ~clk_i;
    end

    // Expected {gate2, gate1, source2, source1} from select, enables and invert bits.
    function automatic logic [3:0] exp_outs(logic [15:0] sl, logic [15:0] gl,
        logic [1:0] pl, lcis_sources_t s);
        logic [7:0] m1, m2, v;
        logic a, b, x, y;
        m2 = {s.multi_compare_unit_2_evt, s.multi_compare_unit_1_evt, 1'b1, s.adc_eoc,
              s.serial1_tx, s.comparator1_out, s.other_cell_out, s.cell_input_pin_b};
        m1 = {s.single_compare_unit_5_evt, s.single_compare_unit_4_evt, 1'b1,
              s.fast_internal_osc, s.low_power_internal_osc, s.secondary_osc,
              s.sys_clk_tcy, s.cell_input_pin_a};
        a = m1[sl[2:0]];
        b = m2[sl[6:4]];
        v = {s.source4, ~s.source4, s.source3, ~s.source3, b, ~b, a, ~a};
        x = (|(v & gl[7:0])) ^ pl[0];
        y = (|(v & gl[15:8])) ^ pl[1];
        return {y, x, b, a};
    endfunction

    task automatic test_done();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // A write is held until waitrequest is sampled low at a rising edge.
    task automatic bus_write(input logic [3:0] a, input logic [15:0] d, input logic [3:0] b);
        @(posedge clk_i);
        adr <= a;
        wdat <= {16'h0000, d};
        be <= b;
        wr <= 1'b1;
        @(posedge clk_i);
        while (wait_o !== 1'b0) @(posedge clk_i);
        wr <= 1'b0;
    endtask

    // A read notes its expected data, and optionally output levels, before it starts.
    task automatic bus_read(input logic [3:0] a, input logic [31:0] d, input logic c,
        input logic [3:0] o);
        expq.push_back({o, c, d});
        @(posedge clk_i);
        adr <= a;
        be <= 4'hF;
        rd <= 1'b1;
        @(posedge clk_i);
        while (wait_o !== 1'b0) @(posedge clk_i);
        rd <= 1'b0;
    endtask

    // The monitor compares each read answer, and the outputs on status reads.
    always @(posedge clk_i) begin
        cycles = cycles + 1;
        if (cycles > 20000) begin
            errors = errors + 1;
            test_done();
        end else if (rd === 1'b1 && wait_o === 1'b0) begin
            note = expq.pop_front();
            checks = checks + 1;
            if (rdat !== note[31:0]) begin
                errors = errors + 1;
                $display("MISMATCH %0t read data %h expected %h", $time, rdat, note[31:0]);
            end
            if (note[32] && {g2, g1, s2, s1} !== note[36:33]) begin
                errors = errors + 1;
                $display("MISMATCH %0t outputs %b expected %b", $time, {g2, g1, s2, s1},
                    note[36:33]);
            end
        end
    end

    // Main sequence: reset values, register access, then every select code pair.
    initial begin
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
        bus_read(LCIS_SEL_OFF, 32'h0, 1'b0, 4'h0);
        bus_read(LCIS_GLSL_OFF, 32'h0, 1'b0, 4'h0);
        bus_read(LCIS_POL_OFF, 32'h0, 1'b0, 4'h0);
        bus_write(LCIS_SEL_OFF, 16'hFFFF, 4'hF);
        bus_read(LCIS_SEL_OFF, {16'h0000, LCIS_SEL_MASK}, 1'b0, 4'h0);
        glsl = 16'($random(seed));
        bus_write(LCIS_GLSL_OFF, glsl, 4'hF);
        bus_write(LCIS_GLSL_OFF, 16'hFFFF, 4'h1);
        bus_read(LCIS_GLSL_OFF, {16'h0000, glsl[15:8], 8'hFF}, 1'b0, 4'h0);
        bus_write(4'h2, 16'hFFFF, 4'hF);
        bus_read(4'h2, 32'h0, 1'b0, 4'h0);
        for (int i = 0; i < 128; i++) begin
            sel = {9'h000, 3'(i >> 3), 1'b0, 3'(i)};
            glsl = (i % 8 == 0) ? 16'h0000 : 16'($random(seed));
            pol = 2'($random(seed));
            @(posedge clk_i);
            step <= 1'b1;
            @(posedge clk_i);
            step <= 1'b0;
            bus_write(LCIS_SEL_OFF, sel, 4'hF);
            bus_write(LCIS_GLSL_OFF, glsl, 4'hF);
            bus_write(LCIS_POL_OFF, {14'h0000, pol}, 4'hF);
            repeat (8) @(posedge clk_i);
            eo = exp_outs(sel, glsl, pol, src);
            bus_read(LCIS_STAT_OFF, {28'h0, eo}, 1'b1, eo);
        end
        test_done();
    end
endmodule
